// file: core/ptu_pkg.sv
// Constants for the three-channel pulse timer unit clock and clear block.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
package ptu_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL0 = 8'h00;
    localparam logic [7:0] OFS_CTRL1 = 8'h04;
    localparam logic [7:0] OFS_CTRL2 = 8'h08;
    localparam logic [7:0] OFS_RUN = 8'h0C;
    localparam logic [7:0] OFS_SYNC = 8'h10;
    localparam logic [7:0] OFS_MODE = 8'h14;
    localparam logic [7:0] OFS_IOFC = 8'h20;
    localparam logic [7:0] OFS_CNT = 8'h30;
    localparam logic [7:0] OFS_GEN = 8'h40;
    // Control register fields
    localparam int CLR_HI = 7;
    localparam int CLR_LO = 5;
    localparam int EDGE_HI = 4;
    localparam int EDGE_LO = 3;
    localparam int SEL_HI = 2;
    localparam int SEL_LO = 0;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [15:0] CNT_RST = 16'h0000;
    // Clear source codes
    localparam logic [2:0] CLR_GA = 3'b001;
    localparam logic [2:0] CLR_GB = 3'b010;
    localparam logic [2:0] CLR_SYNC = 3'b011;
    localparam logic [2:0] CLR_GC = 3'b101;
    localparam logic [2:0] CLR_GD = 3'b110;
    // Prescaler taps: bit k is a square wave of period 2^(k+1)
    localparam int TAP_DIV4 = 1;
    localparam int TAP_DIV16 = 3;
    localparam int TAP_DIV64 = 5;
    localparam int TAP_DIV256 = 7;
    localparam int TAP_DIV1024 = 9;
    localparam int PRE_W = 10;
endpackage : ptu_pkg

// file: core/ptu_clock_clear.sv
// Clock select, edge select and counter clear for three timer channels.
// Assumes pins are asynchronous to clk and a classic Wishbone master.
//
// Contract
// - Four external clocks; A,B are channel-1 quadrature
// - External C,D are channel-2 quadrature inputs
// - Channel pins capture input or compare output
// - Channel 0 four pins; channels 1,2 two
// - Channel 0 two pin controls; others one
// - One shared run and sync register
// - Bits 7:5 select clear source, reset zero
// - Edge 00 rising, 01 falling, 1X both
// - Both edges count every clock transition
// - Quadrature mode overrides edge field
// - Edge field ignored for undivided clock
// - Edge field ignored for cascaded overflow
// - Bits 2:0 select clock, per channel
// - Clear codes: A, B, sync; C, D
// - Channels 1,2 clear bit 7 reads zero
// - Channel 0 clocks: /1,/4,/16,/64, ext A-D
// - Ch1 110 /256, 111 banned; ch2 C,/1024
`timescale 1ns/1ps
module ptu_clock_clear (
    // Clock, enable and reset
    input wire logic clk,
    input wire logic ce,
    input wire logic arst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // External clock pins a..d
    input wire logic [3:0] ext_clock_in,
    // Channel pins: 0..3 ch0 a..d, 4,5 ch1 a,b, 6,7 ch2 a,b
    input wire logic [7:0] io_pin_i,
    output logic [7:0] io_pin_o,
    output logic [7:0] io_pin_oe
);
    // Reset release chain
    logic [1:0] rst_sync_reg;
    logic rst_n;
    // Registers seen by software, and pout_reg, which software cannot read
    logic [7:0] ctrl_reg [3];
    logic [2:0] run_reg;
    logic [2:0] sync_reg;
    logic [1:0] mode_reg;
    logic [7:0] iofc_reg [4];
    logic [15:0] gen_reg [8];
    logic [15:0] cnt_reg [3];
    logic [7:0] pout_reg;
    // Prescaler width, declared ahead of the registers that use it
    localparam int PTU_W = ptu_pkg::PRE_W;
    // Pin synchronisers, third stage for edge detect
    logic [11:0] meta_reg, sync_q_reg, prev_reg;
    logic [PTU_W-1:0] pre_reg, pre_prev_reg;
    // Per-pin and per-channel events
    logic [7:0] pin_ev;
    logic [2:0] tick, clr_own, clr_fire;
    logic [2:0] dir_up;
    // Bus decode
    logic req, wr;
    logic ack_reg;
    logic [31:0] rd_next;
    logic [31:0] rd_reg;

    // Reset is released through two flops so all state leaves reset together
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rst_sync_reg <= 2'b00;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];

    // Two-flop synchronisers; only prev_reg and sync_q_reg feed logic
    // pins synchronised
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= 12'h000;
            sync_q_reg <= 12'h000;
            prev_reg <= 12'h000;
        end
        else if (ce)
        begin
            meta_reg <= {io_pin_i, ext_clock_in};
            sync_q_reg <= meta_reg;
            prev_reg <= sync_q_reg;
        end
    end

    // Free-running prescaler shared by all channels
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pre_reg <= '0;
            pre_prev_reg <= '0;
        end
        else if (ce)
        begin
            pre_reg <= pre_reg + 1'b1;
            pre_prev_reg <= pre_reg;
        end
    end

    // Source of a channel: {enable, edge applies, level}
    // per-channel clock select
    function automatic logic [2:0] pick(input int ch, input logic [2:0] s,
        input logic [PTU_W-1:0] p, input logic [3:0] e);
        logic [2:0] r;
        r = 3'b000;
        unique case (s)
            3'b000: r = 3'b100;
            3'b001: r = {2'b11, p[ptu_pkg::TAP_DIV4]};
            3'b010: r = {2'b11, p[ptu_pkg::TAP_DIV16]};
            3'b011: r = {2'b11, p[ptu_pkg::TAP_DIV64]};
            3'b100: r = {2'b11, e[0]};
            3'b101: r = {2'b11, e[1]};
            // codes 110 and 111 differ per channel
            3'b110:
                r = (ch == 1) ? {2'b11, p[ptu_pkg::TAP_DIV256]} : {2'b11, e[2]};
            3'b111:
                r = (ch == 0) ? {2'b11, e[3]} :
                    (ch == 2) ? {2'b11, p[ptu_pkg::TAP_DIV1024]} : 3'b000;
        endcase
        return r;
    endfunction

    // Edge qualifier on a sampled level
    // edge field decode
    function automatic logic edge_ok(input logic [1:0] f, input logic was,
        input logic now);
        if (f[1])
            return was ^ now;
        else if (f[0])
            return was & ~now;
        else
            return ~was & now;
    endfunction

    // Channel tick and direction
    generate
        for (genvar c = 0; c < 3; c++)
        begin : g_tick
            logic [2:0] cur, old;
            logic qa, qb, qa_p, qb_p, quad;
            assign cur = pick(c, ctrl_reg[c][ptu_pkg::SEL_HI:ptu_pkg::SEL_LO],
                pre_reg, sync_q_reg[3:0]);
            assign old = pick(c, ctrl_reg[c][ptu_pkg::SEL_HI:ptu_pkg::SEL_LO],
                pre_prev_reg, prev_reg[3:0]);
            // quadrature pins: ch1 uses A,B and ch2 uses C,D
            if (c == 0)
            begin : g_noq
                assign {qa, qb, qa_p, qb_p, quad} = 5'b00000;
            end
            else
            begin : g_q
                assign qa = sync_q_reg[2*c-2];
                assign qb = sync_q_reg[2*c-1];
                assign qa_p = prev_reg[2*c-2];
                assign qb_p = prev_reg[2*c-1];
                assign quad = mode_reg[c-1];
            end
            // No select code routes another channel's overflow here, so a
            // cascaded count never reaches edge_ok
            // cascade bypasses edge field
            always_comb
            begin
                dir_up[c] = 1'b1;
                if (!run_reg[c])
                    tick[c] = 1'b0;
                else if (quad)
                begin
                    tick[c] = (qa ^ qa_p) | (qb ^ qb_p);
                    dir_up[c] = qa ^ qb_p;
                end
                else if (!cur[2])
                    tick[c] = 1'b0;
                else if (!cur[1])
                    tick[c] = 1'b1;
                else
                    tick[c] = edge_ok(ctrl_reg[c][ptu_pkg::EDGE_HI:ptu_pkg::EDGE_LO],
                        old[0], cur[0]);
            end
        end
    endgenerate

    // Pin index to owning channel counter
    function automatic int pin_ch(input int i);
        return (i < 4) ? 0 : (i < 6) ? 1 : 2;
    endfunction

    // Per-pin capture or compare, driven from the io control nibble:
    // bit3 capture mode, bits1:0 output action 01 low, 10 high, 11 toggle
    // bidirectional channel pins
    // ch0 owns two io control registers
    generate
        for (genvar i = 0; i < 8; i++)
        begin : g_pin
            logic [3:0] nib;
            logic cap, cmp;
            assign nib = (i % 2 == 1) ? iofc_reg[i/2][7:4] : iofc_reg[i/2][3:0];
            assign cap = nib[3] & sync_q_reg[4+i] & ~prev_reg[4+i];
            assign cmp = ~nib[3] & (cnt_reg[pin_ch(i)] == gen_reg[i]);
            assign pin_ev[i] = cap | cmp;
            assign io_pin_oe[i] = ~nib[3] & (nib[1:0] != 2'b00);
            assign io_pin_o[i] = pout_reg[i];
            // Capture latches the counter, software write otherwise
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    gen_reg[i] <= ptu_pkg::CNT_RST;
                else if (ce && cap)
                    gen_reg[i] <= cnt_reg[pin_ch(i)];
                else if (ce && wr && wb_adr_i == ptu_pkg::OFS_GEN + 8'(4*i))
                begin
                    if (wb_sel_i[0])
                        gen_reg[i][7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1])
                        gen_reg[i][15:8] <= wb_dat_i[15:8];
                end
            end
            // Output level on compare match
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    pout_reg[i] <= 1'b0;
                else if (ce && cmp && !nib[3])
                    pout_reg[i] <= nib[1] & (nib[0] ? ~pout_reg[i] : 1'b1);
            end
        end
    endgenerate

    // Clear source per channel
    // clear code decode
    generate
        for (genvar c = 0; c < 3; c++)
        begin : g_clr
            logic [2:0] code;
            assign code = ctrl_reg[c][ptu_pkg::CLR_HI:ptu_pkg::CLR_LO];
            localparam int PA = (c == 0) ? 0 : 2 * c + 2;
            always_comb
            begin
                unique case (code)
                    ptu_pkg::CLR_GA: clr_own[c] = pin_ev[PA];
                    ptu_pkg::CLR_GB: clr_own[c] = pin_ev[PA+1];
                    ptu_pkg::CLR_GC: clr_own[c] = (c == 0) & pin_ev[2];
                    ptu_pkg::CLR_GD: clr_own[c] = (c == 0) & pin_ev[3];
                    default: clr_own[c] = 1'b0;
                endcase
            end
            // Synchronous clear follows any other synced channel's own clear
            assign clr_fire[c] = clr_own[c] | ((code == ptu_pkg::CLR_SYNC) &
                sync_reg[c] & |(clr_own & sync_reg & ~(3'b001 << c)));
            // Counter: clear beats tick, software write beats both
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    cnt_reg[c] <= ptu_pkg::CNT_RST;
                else if (ce && wr && wb_adr_i == ptu_pkg::OFS_CNT + 8'(4*c))
                begin
                    if (wb_sel_i[0])
                        cnt_reg[c][7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1])
                        cnt_reg[c][15:8] <= wb_dat_i[15:8];
                end
                else if (ce && clr_fire[c])
                    cnt_reg[c] <= ptu_pkg::CNT_RST;
                else if (ce && tick[c])
                    cnt_reg[c] <= dir_up[c] ? cnt_reg[c] + 1'b1 : cnt_reg[c] - 1'b1;
            end
            // Control registers; changes while running take effect at once
            // software halts before changing control
            // ch1/ch2 bit 7 forced to zero
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    ctrl_reg[c] <= ptu_pkg::CTRL_RST;
                else if (ce && wr && wb_sel_i[0] &&
                    wb_adr_i == ptu_pkg::OFS_CTRL0 + 8'(4*c))
                    ctrl_reg[c] <= {wb_dat_i[7] & (c == 0), wb_dat_i[6:0]};
            end
        end
    endgenerate

    // Bus request qualified once; ack drops the cycle after it is given
    assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wr = req & wb_we_i;

    // Shared run, sync and mode registers, plus pin control
    // single shared run and sync
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run_reg <= 3'b000;
            sync_reg <= 3'b000;
            mode_reg <= 2'b00;
            for (int k = 0; k < 4; k++)
                iofc_reg[k] <= 8'h00;
        end
        else if (ce && wr && wb_sel_i[0])
        begin
            if (wb_adr_i == ptu_pkg::OFS_RUN)
                run_reg <= wb_dat_i[2:0];
            if (wb_adr_i == ptu_pkg::OFS_SYNC)
                sync_reg <= wb_dat_i[2:0];
            if (wb_adr_i == ptu_pkg::OFS_MODE)
                mode_reg <= wb_dat_i[1:0];
            for (int k = 0; k < 4; k++)
                if (wb_adr_i == ptu_pkg::OFS_IOFC + 8'(4*k))
                    iofc_reg[k] <= wb_dat_i[7:0];
        end
    end

    // Read mux; unmapped addresses read zero but still ack
    always_comb
    begin
        rd_next = 32'h0000_0000;
        for (int k = 0; k < 3; k++)
        begin
            if (wb_adr_i == ptu_pkg::OFS_CTRL0 + 8'(4*k))
                rd_next = {24'h00_0000, ctrl_reg[k]};
            if (wb_adr_i == ptu_pkg::OFS_CNT + 8'(4*k))
                rd_next = {16'h0000, cnt_reg[k]};
        end
        for (int k = 0; k < 4; k++)
            if (wb_adr_i == ptu_pkg::OFS_IOFC + 8'(4*k))
                rd_next = {24'h00_0000, iofc_reg[k]};
        for (int k = 0; k < 8; k++)
            if (wb_adr_i == ptu_pkg::OFS_GEN + 8'(4*k))
                rd_next = {16'h0000, gen_reg[k]};
        if (wb_adr_i == ptu_pkg::OFS_RUN)
            rd_next = {29'h0000_0000, run_reg};
        if (wb_adr_i == ptu_pkg::OFS_SYNC)
            rd_next = {29'h0000_0000, sync_reg};
        if (wb_adr_i == ptu_pkg::OFS_MODE)
            rd_next = {30'h0000_0000, mode_reg};
    end

    // Ack and read data one cycle after the request
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_reg <= 1'b0;
            rd_reg <= 32'h0000_0000;
        end
        else if (ce)
        begin
            ack_reg <= req;
            if (req)
                rd_reg <= rd_next;
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rd_reg;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_req;
        ce && wb_cyc_i && wb_stb_i && !ack_reg;
    endsequence

    AST_ACK_NEXT: assert property (s_req |=> wb_ack_o)
        else $error("ack missing after request");
    AST_HALT_HOLD: assert property (ce && !run_reg[0] && !clr_fire[0] && !wr
        |=> cnt_reg[0] == $past(cnt_reg[0]))
        else $error("halted counter moved");
    AST_CLR_BIT7: assert property (ctrl_reg[1][7] == 1'b0 && ctrl_reg[2][7] == 1'b0)
        else $error("reserved clear bit set");
    AST_DIV1_EVERY: assert property (ce && run_reg[0] && !mode_reg[0] &&
        ctrl_reg[0][2:0] == 3'b000 |-> tick[0])
        else $error("undivided clock missed a count");
    AST_BANNED: assert property (run_reg[1] && !mode_reg[0] &&
        ctrl_reg[1][2:0] == 3'b111 |-> !tick[1])
        else $error("prohibited select counted");
    AST_BOTH_EDGES: assert property (run_reg[2] && !mode_reg[1] &&
        ctrl_reg[2][4:3] == 2'b10 && ctrl_reg[2][2:0] == 3'b100 &&
        sync_q_reg[0] != prev_reg[0] |-> tick[2])
        else $error("both-edge count missed");
    AST_RISE_ONLY: assert property (run_reg[0] && ctrl_reg[0][4:3] == 2'b00 &&
        ctrl_reg[0][2:0] == 3'b100 && tick[0] |-> sync_q_reg[0] && !prev_reg[0])
        else $error("rising mode counted other edge");
    AST_CLEAR_A: assert property (ce && !wr && ctrl_reg[0][7:5] == 3'b001 &&
        pin_ev[0] |=> cnt_reg[0] == 16'h0000)
        else $error("clear on register A missed");
    AST_QUAD: assert property (run_reg[1] && mode_reg[0] &&
        sync_q_reg[0] == prev_reg[0] && sync_q_reg[1] == prev_reg[1] |-> !tick[1])
        else $error("quadrature counted without pin change");
endmodule : ptu_clock_clear

// file: sim/ptu_pin_model.sv
// Far-side model: external clock sources and channel pin drivers.
// Assumes the bench calls its tasks; all changes land right after clk rises.
`timescale 1ns/1ps
module ptu_pin_model (
    // Clock
    input wire logic clk,
    // Device pin outputs and enables
    input wire logic [7:0] io_pin_o,
    input wire logic [7:0] io_pin_oe,
    // Pins seen by the device
    output logic [3:0] ext_clock_in,
    output logic [7:0] io_pin_i
);
    logic [7:0] drv_reg; // Far-side level on each channel pin
    initial ext_clock_in = 4'h0;
    initial drv_reg = 8'h00;
    // Wire level: device wins where it drives, else the far side
    assign io_pin_i = (io_pin_oe & io_pin_o) | (~io_pin_oe & drv_reg);
    // Wandering pattern so capture inputs never sit still
    always @(posedge clk)
    begin
        drv_reg <= drv_reg + 8'h01;
    end
    // Whole pulses, at least two cycles high and two low
    task automatic pulse(input int pin, input int n);
        repeat (n)
        begin
            repeat (2) @(posedge clk);
            ext_clock_in[pin] <= 1'b1;
            repeat (2) @(posedge clk);
            ext_clock_in[pin] <= 1'b0;
        end
        repeat (2) @(posedge clk);
    endtask
    // Quadrature on pair 0 (a,b) or 1 (c,d); A leads B, so counting goes up
    task automatic quad(input int pair, input int n);
        for (int k = 0; k < n; k++)
        begin
            repeat (2) @(posedge clk);
            ext_clock_in[2 * pair + k % 2] <= ~ext_clock_in[2 * pair + k % 2];
        end
        repeat (2) @(posedge clk);
    endtask
endmodule // ptu_pin_model

// file: sim/ptu_clock_clear_bench.sv
// Self-checking bench for the timer clock and clear block.
// Assumes the pin model file is compiled first; ce is held high.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module ptu_clock_clear_bench;
    logic clk = 1'b0;
    logic ce = 1'b1; // Stalls are not exercised
    logic arst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic ack;
    logic [3:0] ext_clock_in;
    logic [7:0] io_pin_i;
    logic [7:0] io_pin_o;
    logic [7:0] io_pin_oe;
    logic [31:0] seed = 32'h0000_2F47; // Fixed start for repeatable runs
    logic [31:0] r;
    logic [31:0] v [3];
    logic [15:0] c;
    logic [15:0] c0;
    int fails = 0;
    int check_count = 0;
    int n;
    always #5 clk = ~clk;
    ptu_clock_clear ptu_clock_clear_i (.clk(clk), .ce(ce), .arst_n(arst_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .ext_clock_in(ext_clock_in), .io_pin_i(io_pin_i), .io_pin_o(io_pin_o),
        .io_pin_oe(io_pin_oe));
    ptu_pin_model ptu_pin_model_i (.clk(clk), .io_pin_o(io_pin_o),
        .io_pin_oe(io_pin_oe), .ext_clock_in(ext_clock_in), .io_pin_i(io_pin_i));
    // Xorshift source
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Channels 1 and 2 lose the top clear bit
    function automatic logic [7:0] exp_ctrl(input int ch, input logic [7:0] d);
        return (ch == 0) ? d : (d & 8'h7F);
    endfunction
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // One classic cycle; waits for ack under a bound
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int i;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'b0011;
        wdat <= d;
        for (i = 0; i < 20; i++)
        begin
            @(posedge clk);
            if (ack === 1'b1)
                break;
        end
        if (i == 20)
        begin
            fails++;
            print_verdict();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    // Configure, clear, run, feed the pins, halt, read the count
    task automatic run(input int ch, input logic [4:0] cfg, input int how,
        input int pin, input int k, input logic go, output logic [15:0] q);
        logic [31:0] d;
        wr(8'(ptu_pkg::OFS_CTRL0 + 4 * ch), {27'h0, cfg});
        wr(8'(ptu_pkg::OFS_CNT + 4 * ch), 32'h0000_0000);
        wr(ptu_pkg::OFS_RUN, 32'(go) << ch);
        case (how)
            0: ptu_pin_model_i.pulse(pin, k);
            1: ptu_pin_model_i.quad(pin, k);
            default: repeat (k) @(posedge clk);
        endcase
        repeat (4) @(posedge clk);
        wr(ptu_pkg::OFS_RUN, 32'h0000_0000);
        xfer(1'b0, 8'(ptu_pkg::OFS_CNT + 4 * ch), 32'h0, d);
        q = d[15:0];
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK(io_pin_oe, 8'h00)
        for (int ch = 0; ch < 3; ch++)
        begin
            xfer(1'b0, 8'(ptu_pkg::OFS_CTRL0 + 4 * ch), 32'h0, r);
            `CHK(r[7:0], ptu_pkg::CTRL_RST)
        end
        // All three written before any read back, to catch cross-talk
        repeat (6)
        begin
            for (int ch = 0; ch < 3; ch++)
            begin
                v[ch] = xs();
                wr(8'(ptu_pkg::OFS_CTRL0 + 4 * ch), v[ch]);
            end
            for (int ch = 0; ch < 3; ch++)
            begin
                xfer(1'b0, 8'(ptu_pkg::OFS_CTRL0 + 4 * ch), 32'h0, r);
                `CHK(r[7:0], exp_ctrl(ch, v[ch][7:0]))
            end
        end
        // Unmapped place reads zero
        xfer(1'b0, 8'hF0, 32'h0, r);
        `CHK(r, 32'h0000_0000)
        wr(ptu_pkg::OFS_RUN, 32'h0000_0007);
        xfer(1'b0, ptu_pkg::OFS_RUN, 32'h0, r);
        `CHK(r[2:0], 3'b111)
        wr(ptu_pkg::OFS_RUN, 32'h0000_0000);
        // Counters back to zero so every pin sees a match with its general register
        for (int ch = 0; ch < 3; ch++)
            wr(8'(ptu_pkg::OFS_CNT + 4 * ch), 32'h0000_0000);
        // Each pin drives on its own control nibble, and drives high on match
        for (int p = 0; p < 8; p++)
        begin
            wr(8'(ptu_pkg::OFS_IOFC + 4 * (p / 2)), 32'h2 << (4 * (p % 2)));
            `CHK(io_pin_oe, 8'h01 << p)
            @(posedge clk);
            `CHK(io_pin_o[p], 1'b1)
            wr(8'(ptu_pkg::OFS_IOFC + 4 * (p / 2)), 32'h0000_0000);
        end
        // Channel 0 on every external pin and every edge code
        for (int k = 0; k < 4; k++)
            for (int e = 0; e < 4; e++)
            begin
                n = xs() % 8 + 1;
                run(0, {2'(e), 3'(4 + k)}, 0, k, n, 1'b1, c);
                `CHK(c, 16'((e > 1) ? 2 * n : n))
            end
        // Channels 1 and 2 external choices
        for (int k = 0; k < 3; k++)
        begin
            n = xs() % 8 + 1;
            run(2, {2'b00, 3'(4 + k)}, 0, k, n, 1'b1, c);
            `CHK(c, 16'(n))
            if (k < 2)
            begin
                run(1, {2'b01, 3'(4 + k)}, 0, k, n, 1'b1, c);
                `CHK(c, 16'(n))
            end
        end
        // Channel 2 on pin a with both edges; then ch1 banned code 111 and halted ch0 must count zero
        run(2, 5'b10_100, 0, 0, 3, 1'b1, c);
        `CHK(c, 16'h0006)
        run(1, 5'b00_111, 0, 0, 5, 1'b1, c);
        `CHK(c, 16'h0000)
        run(0, 5'b00_100, 0, 0, 5, 1'b0, c);
        `CHK(c, 16'h0000)
        // Undivided clock: edge code must not matter
        run(0, 5'b00_000, 2, 0, 40, 1'b1, c0);
        // Run lasts the idle cycles plus seven bus and settle edges
        `CHK(c0, 16'(40 + 7))
        for (int e = 1; e < 4; e++)
        begin
            run(0, {2'(e), 3'b000}, 2, 0, 40, 1'b1, c);
            `CHK(c, c0)
        end
        // Divide by four: both edges count faster than rising only
        run(0, 5'b00_001, 2, 0, 64, 1'b1, c0);
        run(0, 5'b10_001, 2, 0, 64, 1'b1, c);
        `CHK(c > c0, 1'b1)
        // Quadrature overrides the undivided clock select
        wr(ptu_pkg::OFS_MODE, 32'h0000_0003);
        run(1, 5'b01_000, 1, 0, 8, 1'b1, c);
        `CHK(c, 16'h0008)
        run(2, 5'b01_000, 1, 1, 8, 1'b1, c);
        `CHK(c, 16'h0008)
        print_verdict();
    end
endmodule // ptu_clock_clear_bench
